/* File: design/sfc_pkg.sv */
// Constants and carrier types shared by the serial flash front-end control
package sfc_pkg;

   // Core clock period and derived cycle counts
   localparam int CLK_PERIOD_NS = 50;
   localparam int SOFT_RESET_US = 300;
   // Least times round up to whole core cycles
   localparam int SOFT_RESET_CYCLES = (SOFT_RESET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PIN_RESET_MIN_NS = 1000;
   localparam int PIN_RESET_CYCLES = (PIN_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Command codes of the software reset pair
   localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
   localparam logic [7:0] OP_RESET = 8'h99;

   // Chip-select reset pattern, first sample in the high bit
   localparam logic [3:0] LINK_RESET_PATTERN = 4'h5;

   // Latency table: base count for code 00, step per code
   localparam logic [4:0] DUAL_DUMMY_BASE = 5'h04;
   localparam logic [4:0] QUAD_DUMMY_BASE = 5'h06;

   // Serial clocks taken by the eight mode bits in each read form
   localparam logic [4:0] MODE_CLK_DUAL = 5'h04;
   localparam logic [4:0] MODE_CLK_QUAD_STR = 5'h02;
   localparam logic [4:0] MODE_CLK_QUAD_DTR = 5'h01;

   // Output drive strength in percent
   localparam logic [6:0] DRIVE_PCT_100 = 7'h64;
   localparam logic [6:0] DRIVE_PCT_75 = 7'h4B;
   localparam logic [6:0] DRIVE_PCT_50 = 7'h32;
   localparam logic [6:0] DRIVE_PCT_25 = 7'h19;

   // Positions of the pins in the synchroniser vector
   localparam int PIN_CS = 0;
   localparam int PIN_SCK = 1;
   localparam int PIN_SI = 2;
   localparam int PIN_SHARED = 3;
   localparam int PIN_RST = 4;
   localparam int PIN_COUNT = 5;

   // Reset values of the registered pin samples
   localparam logic [4:0] PIN_SYNC_RESET = 5'h00;

   typedef enum logic [1:0] {
      SFC_RD_DUAL,
      SFC_RD_QUAD_STR,
      SFC_RD_QUAD_DTR
   } sfc_read_mode_t;

   typedef enum logic [1:0] {
      SFC_FR_DESELECTED,
      SFC_FR_ACTIVE,
      SFC_FR_PAUSED
   } sfc_frame_state_t;

   // Configuration held in the non-volatile status bits
   typedef struct packed {
      logic quad_enable;
      logic pause_or_clear_pin_select;
      logic [1:0] dummy_cycle_select;
      logic [1:0] drive_strength_select;
      sfc_read_mode_t read_mode;
      logic qpi_mode;
   } sfc_cfg_t;

   // State reported to the rest of the device
   typedef struct packed {
      logic selected;
      logic standby;
      logic paused;
      logic cmd_accept;
      logic reset_busy;
      logic [4:0] dummy_cycles;
      logic [4:0] dummy_after_mode;
      logic [6:0] drive_pct;
   } sfc_status_t;

endpackage

/* File: design/sfc_ctrl.sv */
// Serial flash front end: latency, drive, select, pause and reset control
`timescale 1ns/1ps

//
// Overview of operation
// - Dual I/O latency 4/8/12/16 by code
// - Quad single-rate latency 6/10/14/18 by code
// - Quad double-rate latency 6/10/14/18 by code
// - Latency counts from address end, includes mode bits
// - Drive strength 100/75/50/25 percent by code
// - Stay unselected until first chip-select falling edge
// - Active while selected; standby when idle and deselected
// - Pause only when quad off and pin selects pause
// - Paused: output high impedance, clock and data ignored
// - Pause enters only while clock low; leaves with clock low or at once when pause is disabled
// - Deselect while paused resets and abandons interface
// - Reset only on consecutive 66h then 99h
// - Soft reset busy about 300 us, no commands
// - Pin select chooses pause or active-low reset
// - Long enough low reset pin restores power-on state
// - Quad enable disables pause and reset pin functions
// - Dedicated reset pin overrides everything, always works
// - Sample data on chip-select rise; 0101 resets
// - No output drive before first serial clock edge
// - Clock activity aborts sequence; fourth pulse resets
// - Latency spans last address clock to first data
module sfc_ctrl #(
   parameter int SOFT_RESET_CYCLES = sfc_pkg::SOFT_RESET_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic serial_clk,
   input wire logic cs_n,
   input wire logic [3:0] io_in,
   input wire logic dedicated_reset_n,
   input wire logic write_busy,
   input wire logic drive_req,
   input wire sfc_pkg::sfc_cfg_t cfg,
   output sfc_pkg::sfc_status_t status,
   output logic data_oe_n,
   output logic cmd_valid,
   output logic [7:0] cmd_byte,
   output logic chip_reset,
   output logic abort_ops,
   output logic frame_abort
);

   // Latency for the selected read form and code
   function automatic logic [4:0] dummy_count(input sfc_pkg::sfc_read_mode_t mode,
                                              input logic [1:0] sel);
      logic [4:0] base;
      base = (mode == sfc_pkg::SFC_RD_DUAL) ? sfc_pkg::DUAL_DUMMY_BASE
                                             : sfc_pkg::QUAD_DUMMY_BASE;
      return base + {1'b0, sel, 2'b00};
   endfunction

   // Serial clocks that the mode bits occupy inside the latency
   function automatic logic [4:0] mode_clocks(input sfc_pkg::sfc_read_mode_t mode);
      case (mode)
         sfc_pkg::SFC_RD_DUAL: return sfc_pkg::MODE_CLK_DUAL;
         sfc_pkg::SFC_RD_QUAD_STR: return sfc_pkg::MODE_CLK_QUAD_STR;
         default: return sfc_pkg::MODE_CLK_QUAD_DTR;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // Link domain: first byte of each frame shifted on serial_clk
   // ---------------------------------------------------------------
   logic link_clr;
   logic link_hold;
   logic [2:0] link_cnt;
   logic [7:0] link_shift;
   logic link_first_done;
   logic [7:0] next_link_shift;
   logic link_byte_done;
   logic [7:0] link_byte;
   logic link_tgl;

   // The frame's own deselect clears the shifter, so no edge after a frame is needed
   assign link_clr = rst | cs_n;

   // Pause pin gates the shifter directly; it only moves while the clock is low,
   // so it is stable at every rising clock edge. Config bits are quasi-static.
   assign link_hold = ~cfg.quad_enable & ~cfg.pause_or_clear_pin_select & ~io_in[3];

   always_comb begin
      if (cfg.qpi_mode) begin
         next_link_shift = {link_shift[3:0], io_in};
      end else begin
         next_link_shift = {link_shift[6:0], io_in[0]};
      end
      link_byte_done = ~link_hold & ~link_first_done &
                       (cfg.qpi_mode ? (link_cnt == 3'd1) : (link_cnt == 3'd7));
   end

   // Bit counter and shifter, cleared by deselect
   always_ff @(posedge serial_clk or posedge link_clr) begin
      if (link_clr) begin
         link_cnt <= 3'd0;
         link_shift <= 8'h00;
         link_first_done <= 1'b0;
      end else if (!link_hold) begin
         link_shift <= next_link_shift;
         link_cnt <= link_cnt + 3'd1;
         if (link_byte_done) begin
            link_first_done <= 1'b1;
         end
      end
   end

   // Byte and toggle survive deselect so the crossing sees no false event
   always_ff @(posedge serial_clk or posedge rst) begin
      if (rst) begin
         link_byte <= 8'h00;
         link_tgl <= 1'b0;
      end else if (link_byte_done) begin
         link_byte <= next_link_shift;
         link_tgl <= ~link_tgl;
      end
   end

   // ---------------------------------------------------------------
   // Core domain: pin synchronisers
   // ---------------------------------------------------------------
   logic [sfc_pkg::PIN_COUNT-1:0] pin_raw;
   logic [sfc_pkg::PIN_COUNT-1:0] pin_meta;
   logic [sfc_pkg::PIN_COUNT-1:0] pin_sync;
   logic [sfc_pkg::PIN_COUNT-1:0] pin_prev;

   assign pin_raw = {dedicated_reset_n, io_in[3], io_in[0], serial_clk, cs_n};

   // Zero reset: a chip select already low at power-up never looks like a falling edge
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pin_meta <= sfc_pkg::PIN_SYNC_RESET;
         pin_sync <= sfc_pkg::PIN_SYNC_RESET;
         pin_prev <= sfc_pkg::PIN_SYNC_RESET;
      end else begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   logic cs_s;
   logic sck_s;
   logic si_s;
   logic shared_s;
   logic ded_s;
   logic cs_fall;
   logic cs_rise;
   logic sck_edge;
   logic shared_fall;

   assign cs_s = pin_sync[sfc_pkg::PIN_CS];
   assign sck_s = pin_sync[sfc_pkg::PIN_SCK];
   assign si_s = pin_sync[sfc_pkg::PIN_SI];
   assign shared_s = pin_sync[sfc_pkg::PIN_SHARED];
   assign ded_s = pin_sync[sfc_pkg::PIN_RST];
   assign cs_fall = pin_prev[sfc_pkg::PIN_CS] & ~cs_s;
   assign cs_rise = ~pin_prev[sfc_pkg::PIN_CS] & cs_s;
   assign sck_edge = pin_prev[sfc_pkg::PIN_SCK] ^ sck_s;
   assign shared_fall = pin_prev[sfc_pkg::PIN_SHARED] & ~shared_s;

   // Byte event crossing: two flops, then an edge stage
   logic [2:0] tgl_sync;
   logic byte_event;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tgl_sync <= 3'b000;
      end else begin
         tgl_sync <= {tgl_sync[1:0], link_tgl};
      end
   end

   // Byte register is stable for at least two serial clocks after the toggle
   assign byte_event = tgl_sync[2] ^ tgl_sync[1];

   // Shared pin function decode
   logic pause_en;
   logic pin_reset_en;

   assign pause_en = ~cfg.quad_enable & ~cfg.pause_or_clear_pin_select;
   assign pin_reset_en = ~cfg.quad_enable & cfg.pause_or_clear_pin_select;

   // ---------------------------------------------------------------
   // Frame state: deselected, active, paused
   // ---------------------------------------------------------------
   sfc_pkg::sfc_frame_state_t frame_state;
   sfc_pkg::sfc_frame_state_t next_frame_state;
   logic next_frame_abort;

   always_comb begin
      next_frame_state = frame_state;
      next_frame_abort = 1'b0;
      case (frame_state)
         sfc_pkg::SFC_FR_DESELECTED: begin
            // Only a seen falling edge selects the device
            if (cs_fall) begin
               next_frame_state = sfc_pkg::SFC_FR_ACTIVE;
            end
         end
         sfc_pkg::SFC_FR_ACTIVE: begin
            if (cs_s) begin
               next_frame_state = sfc_pkg::SFC_FR_DESELECTED;
            end else if (pause_en && shared_fall && !sck_s) begin
               next_frame_state = sfc_pkg::SFC_FR_PAUSED;
            end
         end
         sfc_pkg::SFC_FR_PAUSED: begin
            if (cs_s) begin
               next_frame_state = sfc_pkg::SFC_FR_DESELECTED;
               next_frame_abort = 1'b1;
            end else if (!pause_en || (shared_s && !sck_s)) begin
               next_frame_state = sfc_pkg::SFC_FR_ACTIVE;
            end
         end
         default: begin
            next_frame_state = sfc_pkg::SFC_FR_DESELECTED;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         frame_state <= sfc_pkg::SFC_FR_DESELECTED;
         frame_abort <= 1'b0;
      end else begin
         frame_state <= next_frame_state;
         frame_abort <= next_frame_abort;
      end
   end

   // Serial clock seen in this frame; clears while deselected
   logic sck_seen;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sck_seen <= 1'b0;
      end else if (cs_s) begin
         sck_seen <= 1'b0;
      end else if (sck_edge && frame_state == sfc_pkg::SFC_FR_ACTIVE) begin
         sck_seen <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Hardware reset pins: width filter
   // ---------------------------------------------------------------
   logic hw_low;
   logic [7:0] hw_cnt;
   logic hw_fire;

   // Dedicated pin ignores configuration and wins over everything
   assign hw_low = ~ded_s | (pin_reset_en & ~shared_s);
   assign hw_fire = hw_low && (hw_cnt == 8'(sfc_pkg::PIN_RESET_CYCLES - 1));

   // Counter saturates so one long pulse resets once
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hw_cnt <= 8'h00;
      end else if (!hw_low) begin
         hw_cnt <= 8'h00;
      end else if (hw_cnt != 8'(sfc_pkg::PIN_RESET_CYCLES)) begin
         hw_cnt <= hw_cnt + 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // Command intake and software reset pair
   // ---------------------------------------------------------------
   logic [15:0] soft_cnt;
   logic reset_busy;
   logic cmd_accept;
   logic take_cmd;
   logic reset_armed;
   logic soft_fire;

   assign reset_busy = soft_cnt != 16'h0000;
   // No command while busy or a reset pin is held low
   assign cmd_accept = (frame_state == sfc_pkg::SFC_FR_ACTIVE) & ~reset_busy & ~hw_low;
   assign take_cmd = byte_event & cmd_accept;
   assign soft_fire = take_cmd & reset_armed & (link_byte == sfc_pkg::OP_RESET);

   // Any other command between the two breaks the pair
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reset_armed <= 1'b0;
      end else if (take_cmd) begin
         reset_armed <= link_byte == sfc_pkg::OP_RESET_ENABLE;
      end else if (chip_reset) begin
         reset_armed <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cmd_valid <= 1'b0;
         cmd_byte <= 8'h00;
      end else begin
         cmd_valid <= take_cmd;
         if (take_cmd) begin
            cmd_byte <= link_byte;
         end
      end
   end

   // Recovery period after the software reset pair
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         soft_cnt <= 16'h0000;
      end else if (soft_fire) begin
         soft_cnt <= 16'(SOFT_RESET_CYCLES);
      end else if (reset_busy) begin
         soft_cnt <= soft_cnt - 16'h0001;
      end
   end

   // ---------------------------------------------------------------
   // Chip-select reset sequence
   // ---------------------------------------------------------------
   logic [3:0] seq_bits;
   logic [2:0] seq_cnt;
   logic [3:0] next_seq_bits;
   logic seq_fire;

   assign next_seq_bits = {seq_bits[2:0], si_s};
   assign seq_fire = cs_rise && !sck_seen && !sck_edge && seq_cnt >= 3'd3 &&
                     next_seq_bits == sfc_pkg::LINK_RESET_PATTERN;

   // Clock activity, even between pulses, discards the samples so far
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         seq_bits <= 4'h0;
         seq_cnt <= 3'd0;
      end else if (sck_edge || seq_fire || (cs_rise && sck_seen)) begin
         seq_bits <= 4'h0;
         seq_cnt <= 3'd0;
      end else if (cs_rise) begin
         seq_bits <= next_seq_bits;
         if (seq_cnt != 3'd4) begin
            seq_cnt <= seq_cnt + 3'd1;
         end
      end
   end

   // Any reset source returns the device to its power-on state
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         chip_reset <= 1'b0;
         abort_ops <= 1'b0;
      end else begin
         chip_reset <= soft_fire | hw_fire | seq_fire;
         abort_ops <= hw_fire | seq_fire;
      end
   end

   // ---------------------------------------------------------------
   // Output drive and status
   // ---------------------------------------------------------------
   // Drive only after a clock edge, never while paused or busy
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         data_oe_n <= 1'b1;
      end else begin
         data_oe_n <= ~(drive_req & sck_seen & ~reset_busy & ~cs_s &
                        (next_frame_state == sfc_pkg::SFC_FR_ACTIVE));
      end
   end

   // Latency and drive settings follow the configuration bits
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         status <= '0;
      end else begin
         status.selected <= frame_state != sfc_pkg::SFC_FR_DESELECTED;
         status.standby <= cs_s & ~write_busy;
         status.paused <= frame_state == sfc_pkg::SFC_FR_PAUSED;
         status.cmd_accept <= cmd_accept;
         status.reset_busy <= reset_busy | hw_low;
         status.dummy_cycles <= dummy_count(cfg.read_mode, cfg.dummy_cycle_select);
         // Mode bits sit inside the latency, not on top of it
         status.dummy_after_mode <= dummy_count(cfg.read_mode, cfg.dummy_cycle_select) -
                                    mode_clocks(cfg.read_mode);
         case (cfg.drive_strength_select)
            2'b00: status.drive_pct <= sfc_pkg::DRIVE_PCT_100;
            2'b01: status.drive_pct <= sfc_pkg::DRIVE_PCT_75;
            2'b10: status.drive_pct <= sfc_pkg::DRIVE_PCT_50;
            default: status.drive_pct <= sfc_pkg::DRIVE_PCT_25;
         endcase
      end
   end

endmodule

/* File: bench/sfc_ctrl_properties.sv */
// Concurrent checks on the ports of the serial flash front-end control
`timescale 1ns/1ps
module sfc_ctrl_properties #(
   parameter int SOFT_RESET_CYCLES = 50
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic serial_clk,
   input wire logic cs_n,
   input wire logic [3:0] io_in,
   input wire logic dedicated_reset_n,
   input wire logic write_busy,
   input wire logic drive_req,
   input wire sfc_pkg::sfc_cfg_t cfg,
   input wire sfc_pkg::sfc_status_t status,
   input wire logic data_oe_n,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_byte,
   input wire logic chip_reset,
   input wire logic abort_ops,
   input wire logic frame_abort
);
   logic [4:0] exp_dc;
   logic [4:0] exp_mc;
   logic [6:0] exp_pct;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   // Expected latency and drive from the settings now applied
   always_comb begin
      exp_dc = (cfg.read_mode == sfc_pkg::SFC_RD_DUAL) ? 5'h04 : 5'h06;
      exp_dc = exp_dc + {1'h0, cfg.dummy_cycle_select, 2'h0};
      exp_pct = 7'h64 - 7'h19 * {5'h00, cfg.drive_strength_select};
      case (cfg.read_mode)
         sfc_pkg::SFC_RD_DUAL: exp_mc = sfc_pkg::MODE_CLK_DUAL;
         sfc_pkg::SFC_RD_QUAD_STR: exp_mc = sfc_pkg::MODE_CLK_QUAD_STR;
         default: exp_mc = sfc_pkg::MODE_CLK_QUAD_DTR;
      endcase
   end

   // Settings must have settled for three cycles before the status is judged
   AST_DUMMY: assert property ($stable(cfg)[*3] |-> status.dummy_cycles == exp_dc)
      else $error("latency count wrong");
   AST_MODE: assert property ($stable(cfg)[*3] |-> status.dummy_after_mode == exp_dc - exp_mc)
      else $error("latency after mode bits wrong");
   AST_DRIVE: assert property ($stable(cfg)[*3] |-> status.drive_pct == exp_pct)
      else $error("drive strength wrong");
   AST_STANDBY: assert property ((cs_n && !write_busy && !status.reset_busy)[*6] |-> status.standby)
      else $error("idle device not in standby");
   AST_BUSY: assert property (write_busy[*4] |-> !status.standby)
      else $error("standby during write cycle");
   AST_SOFT: assert property (cmd_valid && chip_reset |=> status.reset_busy[*8])
      else $error("soft reset recovery too short");
   AST_REFUSE: assert property (status.reset_busy |-> !cmd_valid)
      else $error("command taken while resetting");
   AST_ABORT: assert property (abort_ops |-> chip_reset && !cmd_valid)
      else $error("abort without reset");
   AST_DEDIC: assert property (!dedicated_reset_n[*5] |-> status.reset_busy)
      else $error("dedicated reset ignored");
   AST_QUAD: assert property (cfg.quad_enable[*3] |-> !status.paused)
      else $error("pause with quad enabled");
   AST_HIZ: assert property (!data_oe_n |=> !status.paused)
      else $error("output driven while paused");
   AST_OE: assert property (!data_oe_n |-> $past(drive_req))
      else $error("output driven without request");
   AST_PULSE: assert property (frame_abort |=> !frame_abort && !cmd_valid)
      else $error("frame abort longer than a cycle");

   cover property (status.paused ##[1:20] frame_abort);
   cover property (chip_reset && abort_ops);
   cover property (cmd_valid && chip_reset);
endmodule

/* File: bench/sfc_host.sv */
// Host controller model driving select, serial clock and data pins
`timescale 1ns/1ps
module sfc_host (
   output logic serial_clk,
   output logic cs_n,
   output logic [3:0] io_in
);
   // Mode 0 idle: clock low, deselected, shared pin pulled high
   initial begin
      serial_clk = 1'h0;
      cs_n = 1'h1;
      io_in = 4'hF;
   end

   // Released data line shows the inverse so a stale level never passes
   task automatic sel(input logic v);
      #80 cs_n = v;
      if (v) io_in[0] = ~io_in[0];
      #80;
   endtask

   // Data moves while the clock is low, highest bit first, 160 ns clock
   task automatic bits(input logic [7:0] b, input int n);
      for (int i = 7; i > 7 - n; i--) begin
         io_in[0] = b[i];
         #80 serial_clk = 1'h1;
         #80 serial_clk = 1'h0;
      end
   endtask

   // Shared pin changes only with the clock low
   task automatic pin3(input logic v);
      #40 io_in[3] = v;
      #80;
   endtask

   // One select pulse with data set as select falls, clock held low
   task automatic cs_pulse(input logic v);
      #80 io_in[0] = v;
      cs_n = 1'h0;
      #160 cs_n = 1'h1;
      #160;
   endtask

   // Stray clock pulse with the device deselected
   task automatic tick;
      #80 serial_clk = 1'h1;
      #80 serial_clk = 1'h0;
   endtask

   // Four-line frame: high nibble then low nibble, shared pin pulled up after
   task automatic qpi(input logic [7:0] b);
      sel(1'h0);
      for (int i = 1; i >= 0; i--) begin
         io_in = b[4*i +: 4];
         #80 serial_clk = 1'h1;
         #80 serial_clk = 1'h0;
      end
      io_in[3:1] = 3'h7;
      sel(1'h1);
   endtask
endmodule

/* File: bench/tb.sv */
// Self-checking bench for the serial flash front-end control
`timescale 1ns/1ps
`define CHK(got, exp) begin \
   check_count++; \
   if ((got) !== (exp)) begin \
      errors++; \
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); \
   end \
end
module tb;
   logic core_clk = 1'h0;
   logic rst = 1'h1;
   logic serial_clk;
   logic cs_n;
   logic [3:0] io_in;
   logic dedicated_reset_n = 1'h1;
   logic write_busy = 1'h0;
   logic drive_req = 1'h0;
   sfc_pkg::sfc_cfg_t cfg = '0;
   sfc_pkg::sfc_status_t status;
   logic data_oe_n, cmd_valid, chip_reset, abort_ops, frame_abort;
   logic [7:0] cmd_byte;
   logic [4:0] dc;
   logic [4:0] mc [3] = '{5'h04, 5'h02, 5'h01};
   int errors = 0;
   int check_count = 0;
   int n_cmd = 0;
   int n_rst = 0;
   int n_abt = 0;
   int n_fab = 0;

   sfc_ctrl #(.SOFT_RESET_CYCLES(50)) u_sfc_ctrl (
      .core_clk(core_clk), .rst(rst), .serial_clk(serial_clk), .cs_n(cs_n),
      .io_in(io_in), .dedicated_reset_n(dedicated_reset_n), .write_busy(write_busy),
      .drive_req(drive_req), .cfg(cfg), .status(status), .data_oe_n(data_oe_n),
      .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .chip_reset(chip_reset),
      .abort_ops(abort_ops), .frame_abort(frame_abort)
   );
   sfc_host u_sfc_host (.serial_clk(serial_clk), .cs_n(cs_n), .io_in(io_in));

   // 20 MHz core clock
   always #25 core_clk = ~core_clk;

   // Pulses stand one cycle, so each is tallied once, on the edge after the one it appears on
   always @(posedge core_clk) begin
      if (cmd_valid === 1'h1) n_cmd++;
      if (chip_reset === 1'h1) n_rst++;
      if (abort_ops === 1'h1) n_abt++;
      if (frame_abort === 1'h1) n_fab++;
   end

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   task automatic send(input logic [7:0] b);
      u_sfc_host.sel(1'h0);
      u_sfc_host.bits(b, 8);
      u_sfc_host.sel(1'h1);
      wait_cyc(4);
   endtask

   task automatic finish_test;
      $display("checks=%0d errors=%0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Bounded wait for soft reset recovery to end
   task automatic wait_idle;
      int k;
      for (k = 0; k < 200 && status.reset_busy !== 1'h0; k++) wait_cyc(1);
      if (k == 200) begin
         errors++;
         finish_test();
      end
   endtask

   // Watchdog against a hung sequence
   initial begin
      #2ms;
      errors++;
      finish_test();
   end

   initial begin
      // Select already low while in reset; released after seven core cycles
      fork
         u_sfc_host.sel(1'h0);
         wait_cyc(7);
      join
      rst = 1'h0;
      u_sfc_host.bits(8'h9F, 8);
      u_sfc_host.sel(1'h1);
      wait_cyc(8);
      `CHK(n_cmd, 0)
      `CHK(status.standby, 1'h1)
      write_busy = 1'h1;
      wait_cyc(6);
      `CHK(status.standby, 1'h0)
      write_busy = 1'h0;
      $display("test select done");
      for (int m = 0; m < 3; m++) begin
         for (int c = 0; c < 4; c++) begin
            cfg.read_mode = sfc_pkg::sfc_read_mode_t'(m);
            cfg.dummy_cycle_select = 2'(c);
            cfg.drive_strength_select = 2'(c);
            wait_cyc(4);
            dc = ((m == 0) ? 5'h04 : 5'h06) + 5'(c) * 5'h04;
            `CHK(status.dummy_cycles, dc)
            `CHK(status.dummy_after_mode, dc - mc[m])
            `CHK(status.drive_pct, 7'h64 - 7'h19 * 7'(c))
         end
      end
      cfg = '0;
      $display("test latency done");
      u_sfc_host.sel(1'h0);
      wait_cyc(6);
      drive_req = 1'h1;
      wait_cyc(4);
      `CHK(status.selected, 1'h1)
      `CHK(status.cmd_accept, 1'h1)
      `CHK(data_oe_n, 1'h1)
      u_sfc_host.bits(8'h9F, 8);
      wait_cyc(8);
      `CHK(data_oe_n, 1'h0)
      `CHK(cmd_byte, 8'h9F)
      drive_req = 1'h0;
      u_sfc_host.sel(1'h1);
      $display("test command done");
      send(8'h66);
      send(8'h99);
      `CHK(n_rst, 1)
      `CHK(status.reset_busy, 1'h1)
      send(8'h05);
      `CHK(n_cmd, 3)
      wait_idle();
      send(8'h66);
      send(8'h05);
      send(8'h99);
      `CHK(n_rst, 1)
      `CHK(cmd_byte, 8'h99)
      $display("test soft reset done");
      u_sfc_host.sel(1'h0);
      u_sfc_host.bits(8'hA5, 3);
      u_sfc_host.pin3(1'h0);
      wait_cyc(6);
      drive_req = 1'h1;
      wait_cyc(2);
      `CHK(status.paused, 1'h1)
      `CHK(data_oe_n, 1'h1)
      `CHK(status.cmd_accept, 1'h0)
      drive_req = 1'h0;
      u_sfc_host.bits(8'h00, 3);
      u_sfc_host.pin3(1'h1);
      wait_cyc(6);
      `CHK(status.paused, 1'h0)
      u_sfc_host.bits(8'h28, 5);
      u_sfc_host.sel(1'h1);
      wait_cyc(6);
      `CHK(cmd_byte, 8'hA5)
      u_sfc_host.sel(1'h0);
      u_sfc_host.bits(8'hFF, 2);
      u_sfc_host.pin3(1'h0);
      wait_cyc(6);
      u_sfc_host.sel(1'h1);
      wait_cyc(6);
      `CHK(n_fab, 1)
      u_sfc_host.pin3(1'h1);
      send(8'h3C);
      `CHK(cmd_byte, 8'h3C)
      $display("test pause done");
      cfg.quad_enable = 1'h1;
      u_sfc_host.sel(1'h0);
      u_sfc_host.pin3(1'h0);
      wait_cyc(6);
      `CHK(status.paused, 1'h0)
      u_sfc_host.sel(1'h1);
      wait_cyc(2);
      cfg.pause_or_clear_pin_select = 1'h1;
      wait_cyc(30);
      `CHK(n_rst, 1)
      cfg.quad_enable = 1'h0;
      wait_cyc(30);
      `CHK(status.reset_busy, 1'h1)
      u_sfc_host.pin3(1'h1);
      wait_cyc(6);
      `CHK(n_rst, 2)
      `CHK(n_abt, 1)
      $display("test pin reset done");
      cfg.quad_enable = 1'h1;
      dedicated_reset_n = 1'h0;
      send(8'h5A);
      `CHK(status.reset_busy, 1'h1)
      `CHK(cmd_byte, 8'h3C)
      dedicated_reset_n = 1'h1;
      wait_cyc(6);
      `CHK(n_rst, 3)
      `CHK(n_abt, 2)
      // Reset pair again, sent over four lines
      cfg.qpi_mode = 1'h1;
      u_sfc_host.qpi(8'h66);
      wait_cyc(4);
      u_sfc_host.qpi(8'h99);
      wait_cyc(4);
      `CHK(cmd_byte, 8'h99)
      `CHK(n_rst, 4)
      wait_idle();
      cfg = '0;
      $display("test dedicated reset done");
      for (int i = 0; i < 4; i++) u_sfc_host.cs_pulse(i[0]);
      wait_cyc(6);
      `CHK(n_rst, 5)
      `CHK(n_abt, 3)
      u_sfc_host.tick();
      u_sfc_host.cs_pulse(1'h0);
      u_sfc_host.cs_pulse(1'h1);
      u_sfc_host.tick();
      u_sfc_host.cs_pulse(1'h0);
      u_sfc_host.cs_pulse(1'h1);
      wait_cyc(6);
      `CHK(n_rst, 5)
      $display("test select reset done");
      finish_test();
   end
endmodule

bind sfc_ctrl sfc_ctrl_properties #(.SOFT_RESET_CYCLES(SOFT_RESET_CYCLES)) u_props (
   .core_clk(core_clk), .rst(rst), .serial_clk(serial_clk), .cs_n(cs_n), .io_in(io_in),
   .dedicated_reset_n(dedicated_reset_n), .write_busy(write_busy), .drive_req(drive_req),
   .cfg(cfg), .status(status), .data_oe_n(data_oe_n), .cmd_valid(cmd_valid),
   .cmd_byte(cmd_byte), .chip_reset(chip_reset), .abort_ops(abort_ops),
   .frame_abort(frame_abort)
);
